// >>> core/rvw_prio.sv
// ----------------
// priority pick by level, then index, of the highest enabled request
// ----------------
module rvw_prio (
    input wire logic [rvw_pkg::NSRC-1:0] req_in,
    input wire logic [2*rvw_pkg::NSRC-1:0] level_in,
    output logic any_out,
    output logic [4:0] idx_out
);
    // higher level wins, equal level keeps table order (lower index first)
    always_comb begin
        logic [1:0] best;
        best = 2'h0;
        any_out = 1'b0;
        idx_out = 5'h00;
        for (int i = 0; i < rvw_pkg::NSRC; i++) begin
            if (req_in[i] && (!any_out || level_in[2*i +: 2] > best)) begin
                any_out = 1'b1;
                best = level_in[2*i +: 2];
                idx_out = 5'(i);
            end
        end
    end
endmodule

// >>> core/rvw_top.sv
module rvw_top (
    input wire logic CORE_CLK_IN,
    input wire logic RSTN_IN,
    // apb
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [11:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    output logic [31:0] PRDATA_OUT,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT,
    // reset causes, one-cycle pulses from same-clock logic
    input wire logic POR_IN,
    input wire logic LOW_VOLTAGE_RESET_IN,
    input wire logic ILLEGAL_ADDR_IN,
    input wire logic CLKMON_FAIL_IN,
    input wire logic WDOG_TIMEOUT_IN,
    // pins, synchronised here
    input wire logic RESET_PIN_N_IN,
    input wire logic NONMASKABLE_IRQ_PIN_N_IN,
    input wire logic IRQ_PIN_N_IN,
    // peripheral requests, index 2..21 used
    input wire logic [21:0] PERIPH_REQ_IN,
    // cpu side
    input wire logic CPU_IBIT_IN,
    input wire logic CPU_XBIT_IN,
    input wire logic WAIT_INSTR_IN,
    input wire logic STOP_INSTR_IN,
    input wire logic FLASH_BUSY_IN,
    input wire logic DEBUG_ACTIVE_IN,
    input wire logic [7:0] PERIPH_CLK_OFF_IN,
    output logic RESET_REQ_OUT,
    output logic [15:0] RESET_VEC_OUT,
    output logic IRQ_PENDING_OUT,
    output logic NMI_PENDING_OUT,
    output logic [15:0] IRQ_VEC_OUT,
    output logic [7:0] CLK_GATE_OUT,
    output logic [3:0] FREEZE_OUT,
    output logic USE_PLL_CLK_OUT,
    output logic [1:0] MODE_OUT
);
    // ----------------
    // helpers
    // ----------------
    function automatic logic [7:0] ofs_of(input logic [4:0] i);
        ofs_of = rvw_pkg::SRC_OFS[8*i +: 8];
    endfunction

    // ----------------
    // pin synchronisers
    // ----------------
    logic [2:0] pin_s1_q, pin_s1_d, pin_s2_q, pin_s2_d;
    always_comb begin
        pin_s1_d = {~RESET_PIN_N_IN, ~NONMASKABLE_IRQ_PIN_N_IN, ~IRQ_PIN_N_IN};
        pin_s2_d = pin_s1_q;
    end
    // preset to idle so a pin low at reset is not seen as an event
    always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            pin_s1_q <= 3'h0;
            pin_s2_q <= 3'h0;
        end else begin
            pin_s1_q <= pin_s1_d;
            pin_s2_q <= pin_s2_d;
        end
    end
    logic rst_pin, nmi_pin, irq_pin;
    assign rst_pin = pin_s2_q[2];
    assign nmi_pin = pin_s2_q[1];
    assign irq_pin = pin_s2_q[0];

    // ----------------
    // registers
    // ----------------
    logic [31:0] ctrl_q, ctrl_d;
    logic [7:0] base_q, base_d;
    logic [21:0] en_q, en_d;
    logic [43:0] lvl_q, lvl_d;
    logic [3:0] frz_q, frz_d;
    logic [15:0] rvec_q, rvec_d;
    logic rreq_q, rreq_d;
    logic [15:0] ivec_q, ivec_d;
    logic ipend_q, ipend_d, npend_q, npend_d;
    rvw_pkg::rvw_mode_t mode_q, mode_d;
    logic stop_hold_q, stop_hold_d;
    logic fast_q, fast_d;
    logic [31:0] rdata_q, rdata_d;
    logic wr, rd, hit;

    assign wr = PSEL_IN && PENABLE_IN && PWRITE_IN;
    assign rd = PSEL_IN && !PENABLE_IN && !PWRITE_IN; // latched at setup so the data stands in the access cycle

    // ----------------
    // request gathering and selection
    // ----------------
    logic [21:0] raw, live, stop_ok;
    logic any;
    logic [4:0] idx;
    always_comb begin
        raw = PERIPH_REQ_IN;
        raw[rvw_pkg::SRC_NMI] = nmi_pin;
        raw[1] = irq_pin;
        // local enables, the nmi pin has none
        live = raw & (en_q | 22'h000001);
        // only the converter is gated in stop by its keep-on bit
        stop_ok = live & rvw_pkg::STOP_WAKE;
        if (!ctrl_q[rvw_pkg::CTRL_ATD_ON])
            stop_ok[rvw_pkg::SRC_ATD] = 1'b0;
    end
    rvw_prio u_prio (
        .req_in(live & ~22'h000001),
        .level_in(lvl_q),
        .any_out(any),
        .idx_out(idx)
    );
    logic unmasked, nmi_live, wake_wait, wake_stop;
    assign nmi_live = live[rvw_pkg::SRC_NMI] && !CPU_XBIT_IN;
    assign unmasked = (any && !CPU_IBIT_IN) || nmi_live;
    // wait ends on pins or any unmasked request
    assign wake_wait = rst_pin || nmi_pin || irq_pin || unmasked;
    assign wake_stop = rst_pin || nmi_live || (|stop_ok[21:1] && !CPU_IBIT_IN);

    // ----------------
    // reset vector and request outputs
    // ----------------
    always_comb begin
        rreq_d = 1'b0;
        rvec_d = rvec_q;
        if (POR_IN || LOW_VOLTAGE_RESET_IN || ILLEGAL_ADDR_IN || rst_pin) begin
            rreq_d = 1'b1;
            rvec_d = {8'hff, rvw_pkg::VEC_RESET_TOP};
        end else if (CLKMON_FAIL_IN && ctrl_q[rvw_pkg::CTRL_CME] && !ctrl_q[rvw_pkg::CTRL_SELF_CLOCK_ENABLE]) begin
            rreq_d = 1'b1;
            rvec_d = {8'hff, rvw_pkg::VEC_CLKMON};
        end else if (WDOG_TIMEOUT_IN && ctrl_q[rvw_pkg::CTRL_RATE_LO +: 3] != 3'h0) begin
            rreq_d = 1'b1;
            rvec_d = {8'hff, rvw_pkg::VEC_WDOG};
        end
        // pending vector, nmi first then the priority pick
        npend_d = nmi_live;
        ipend_d = any && !CPU_IBIT_IN;
        if (nmi_live)
            ivec_d = {base_q, rvw_pkg::VEC_NMI};
        else if (ipend_d) // a pick masked by the i bit is not offered
            ivec_d = {base_q, ofs_of(idx)};
        else
            ivec_d = {base_q, rvw_pkg::VEC_SPURIOUS};
    end

    // ----------------
    // power mode sequencer
    // ----------------
    always_comb begin
        mode_d = mode_q;
        stop_hold_d = stop_hold_q;
        fast_d = fast_q;
        case (mode_q)
            rvw_pkg::RVW_RUN: begin
                fast_d = 1'b0;
                if (WAIT_INSTR_IN) begin
                    mode_d = rvw_pkg::RVW_WAIT;
                end else if (STOP_INSTR_IN || stop_hold_q) begin
                    if (unmasked) begin
                        stop_hold_d = 1'b0;
                    end else if (FLASH_BUSY_IN) begin
                        stop_hold_d = 1'b1;
                    end else begin
                        stop_hold_d = 1'b0;
                        mode_d = ctrl_q[rvw_pkg::CTRL_PSEUDO_STOP_SELECT] ? rvw_pkg::RVW_PSTOP : rvw_pkg::RVW_FSTOP;
                    end
                end
            end
            rvw_pkg::RVW_WAIT: begin
                if (wake_wait)
                    mode_d = rvw_pkg::RVW_RUN;
            end
            rvw_pkg::RVW_FSTOP: begin
                if (wake_stop) begin
                    mode_d = rvw_pkg::RVW_RUN;
                    fast_d = ctrl_q[rvw_pkg::CTRL_FASTWK];
                end
            end
            rvw_pkg::RVW_PSTOP: begin
                if (wake_stop || (live[rvw_pkg::SRC_TICK] && !CPU_IBIT_IN))
                    mode_d = rvw_pkg::RVW_RUN;
            end
            default: mode_d = rvw_pkg::RVW_RUN;
        endcase
    end

    // ----------------
    // apb slave: zero wait, error on unmapped
    // ----------------
    always_comb begin
        ctrl_d = ctrl_q;
        base_d = base_q;
        en_d = en_q;
        lvl_d = lvl_q;
        frz_d = frz_q;
        rdata_d = rdata_q;
        hit = 1'b1;
        case (PADDR_IN)
            rvw_pkg::ADDR_CTRL: begin
                if (wr) ctrl_d = PWDATA_IN & 32'h0000_073f;
                rdata_d = ctrl_q;
            end
            rvw_pkg::ADDR_BASE: begin
                if (wr) base_d = PWDATA_IN[7:0];
                rdata_d = {24'h0, base_q};
            end
            rvw_pkg::ADDR_EXT_IRQ_ENABLE: begin
                if (wr) en_d = PWDATA_IN[21:0];
                rdata_d = {10'h0, en_q};
            end
            rvw_pkg::ADDR_LEVEL0: begin
                if (wr) lvl_d[31:0] = PWDATA_IN;
                rdata_d = lvl_q[31:0];
            end
            rvw_pkg::ADDR_LEVEL1: begin
                if (wr) lvl_d[43:32] = PWDATA_IN[11:0];
                rdata_d = {20'h0, lvl_q[43:32]};
            end
            rvw_pkg::ADDR_FRZ: begin
                if (wr) frz_d = PWDATA_IN[3:0];
                rdata_d = {28'h0, frz_q};
            end
            rvw_pkg::ADDR_STAT: rdata_d = {26'h0, fast_q, stop_hold_q, npend_q, ipend_q, mode_q};
            rvw_pkg::ADDR_VEC: rdata_d = {16'h0, ivec_q};
            rvw_pkg::ADDR_GATE: rdata_d = {24'h0, CLK_GATE_OUT};
            default: begin
                hit = 1'b0;
                rdata_d = 32'h0;
            end
        endcase
        if (!rd) rdata_d = rdata_q;
    end

    always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            ctrl_q <= rvw_pkg::CTRL_RESET;
            base_q <= rvw_pkg::BASE_RESET;
            en_q <= 22'h0;
            lvl_q <= 44'h0;
            frz_q <= 4'h0;
            rvec_q <= 16'hfffe;
            rreq_q <= 1'b0;
            ivec_q <= 16'hff10;
            ipend_q <= 1'b0;
            npend_q <= 1'b0;
            mode_q <= rvw_pkg::RVW_RUN;
            stop_hold_q <= 1'b0;
            fast_q <= 1'b0;
            rdata_q <= 32'h0;
        end else begin
            ctrl_q <= ctrl_d;
            base_q <= base_d;
            en_q <= en_d;
            lvl_q <= lvl_d;
            frz_q <= frz_d;
            rvec_q <= rvec_d;
            rreq_q <= rreq_d;
            ivec_q <= ivec_d;
            ipend_q <= ipend_d;
            npend_q <= npend_d;
            mode_q <= mode_d;
            stop_hold_q <= stop_hold_d;
            fast_q <= fast_d;
            rdata_q <= rdata_d;
        end
    end

    // ----------------
    // clock gates and outputs
    // ----------------
    rvw_pkg::rvw_gate_t g;
    always_comb begin
        g = '1;
        case (mode_q)
            rvw_pkg::RVW_WAIT: begin
                g.cpu_clk_on = 1'b0;
                g.periph_on = !(&PERIPH_CLK_OFF_IN);
            end
            rvw_pkg::RVW_FSTOP: begin
                g = '0;
                g.api_on = ctrl_q[rvw_pkg::CTRL_API_ON];
                g.atd_on = ctrl_q[rvw_pkg::CTRL_ATD_ON];
            end
            rvw_pkg::RVW_PSTOP: begin
                g.cpu_clk_on = 1'b0;
                g.sys_clk_on = 1'b0;
                g.periph_on = 1'b0;
                g.api_on = ctrl_q[rvw_pkg::CTRL_API_ON];
                g.atd_on = ctrl_q[rvw_pkg::CTRL_ATD_ON];
            end
            default: ;
        endcase
    end

    // freeze only while debug is active and the per-unit option is set
    assign FREEZE_OUT = DEBUG_ACTIVE_IN ? frz_q : 4'h0;
    assign CLK_GATE_OUT = g;
    assign RESET_REQ_OUT = rreq_q;
    assign RESET_VEC_OUT = rvec_q;
    assign IRQ_PENDING_OUT = ipend_q;
    assign NMI_PENDING_OUT = npend_q;
    assign IRQ_VEC_OUT = ivec_q;
    assign USE_PLL_CLK_OUT = fast_q;
    assign MODE_OUT = mode_q;
    assign PRDATA_OUT = rdata_q;
    assign PREADY_OUT = 1'b1;
    assign PSLVERR_OUT = PSEL_IN && PENABLE_IN && !hit;
endmodule

// >>> include/rvw_pkg.sv
// ----------------
// Contract
// - power-on, low-voltage, pin and illegal-address resets share the top vector
// - clock monitor failure resets through its own vector when monitor bits allow
// - watchdog time-out resets through its own vector when rate is non-zero
// - vectors ordered by fixed priority, highest offset first, relative to base
// - each maskable request has an enable and a priority level
// - wait instruction halts execution and gates the cpu clock only
// - wait ends on reset, nmi pin, irq pin or any unmasked request
// - in wait each peripheral may gate its own clock; here one shared gate, off only when all eight ask
// - full stop halts oscillator and all clocks, freezing counters
// - wakeup timer and converter may stay on and wake from full stop; here the wakeup timer has no request, only the converter wakes
// - fast wakeup leaves full stop at once on the pll clock
// - pseudo stop keeps oscillator; only tick, watchdog, wakeup timer, converter run
// - timer, pwm, converter, periodic timer may freeze while debug is active
// - timer channels, overflow, accumulator use own vectors; wake wait only
// - serial, converter, port and external pins wake from stop and wait
// - pll lock and self clock requests have own vectors and enables
// - stop instruction enters stop unless flash busy; select picks pseudo or full
// - stop waits for flash; unmasked request meanwhile cancels the stop
// ----------------
package rvw_pkg;
    // ----------------
    // apb register map
    // ----------------
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_BASE = 12'h004;
    localparam logic [11:0] ADDR_EXT_IRQ_ENABLE = 12'h008;
    localparam logic [11:0] ADDR_LEVEL0 = 12'h00c;
    localparam logic [11:0] ADDR_LEVEL1 = 12'h010;
    localparam logic [11:0] ADDR_FRZ = 12'h014;
    localparam logic [11:0] ADDR_STAT = 12'h018;
    localparam logic [11:0] ADDR_VEC = 12'h01c;
    localparam logic [11:0] ADDR_GATE = 12'h020;
    // ctrl fields
    localparam int CTRL_PSEUDO_STOP_SELECT = 0;
    localparam int CTRL_FASTWK = 1;
    localparam int CTRL_CME = 2;
    localparam int CTRL_SELF_CLOCK_ENABLE = 3;
    localparam int CTRL_API_ON = 4;
    localparam int CTRL_ATD_ON = 5;
    localparam int CTRL_RATE_LO = 8;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [7:0] BASE_RESET = 8'hff;
    // ----------------
    // sources, index order is priority order among equal levels
    // ----------------
    localparam int NSRC = 22;
    localparam logic [7:0] VEC_RESET_TOP = 8'hfe;
    localparam logic [7:0] VEC_CLKMON = 8'hfc;
    localparam logic [7:0] VEC_WDOG = 8'hfa;
    localparam logic [7:0] VEC_SPURIOUS = 8'h10;
    localparam logic [7:0] VEC_NMI = 8'hf4;
    // offsets indexed by source; 0 = nmi pin, 1 = irq pin
    localparam logic [8*NSRC-1:0] SRC_OFS = {
        8'hc4, 8'hc6, 8'hcc, 8'hce, 8'hd2, 8'hd4, 8'hd6, 8'hd8, 8'hda, 8'hdc, 8'hde,
        8'he0, 8'he2, 8'he4, 8'he6, 8'he8, 8'hea, 8'hec, 8'hee, 8'hf0, 8'hf2, 8'hf4};
    // stop wake capability per source (bit = index)
    localparam logic [NSRC-1:0] STOP_WAKE = 22'b00_1111_1000_0000_0000_0011;
    localparam int SRC_TICK = 2;
    localparam int SRC_ATD = 17;
    localparam int SRC_LOCK = 20;
    localparam int SRC_SCM = 21;
    localparam int SRC_NMI = 0;

    typedef enum logic [1:0] {RVW_RUN, RVW_WAIT, RVW_FSTOP, RVW_PSTOP} rvw_mode_t;
    typedef struct packed {
        logic osc_on;
        logic cpu_clk_on;
        logic sys_clk_on;
        logic tick_on;
        logic wdog_on;
        logic api_on;
        logic atd_on;
        logic periph_on;
    } rvw_gate_t;
endpackage

// >>> verification/rvw_cpu_model.sv
// ----------------
// cpu core: takes a vector only for a request it may recognise
// ----------------
module rvw_cpu_model (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic ibit_in,
    input wire logic xbit_in,
    input wire logic irq_pend_in,
    input wire logic nmi_pend_in,
    input wire logic [15:0] vec_in,
    output logic fetch_out,
    output logic [15:0] addr_out
);
    timeunit 1ns;
    timeprecision 100ps;
    // a masked request leaves the last fetch address untouched
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            fetch_out <= 1'b0;
            addr_out <= 16'h0000;
        end else begin
            fetch_out <= (nmi_pend_in && !xbit_in) || (irq_pend_in && !ibit_in);
            if ((nmi_pend_in && !xbit_in) || (irq_pend_in && !ibit_in)) begin
                addr_out <= vec_in;
            end
        end
    end
endmodule

// >>> verification/rvw_top_bench.sv
module rvw_top_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk, rstn, psel, pen, pwr, por, low_voltage_reset, ill, cmf, wdt, rpin_n, nmi_n, irq_n, ibit, xbit, wait_instruction, stp;
    logic fbusy, dbg, pready, pslverr, err, rreq, ipend, npend, pll, fetch;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, lfsr;
    logic [21:0] preq;
    logic [7:0] poff, base, gate;
    logic [15:0] rvec, ivec, faddr;
    logic [3:0] frz;
    logic [1:0] mode;
    logic [43:0] lev;
    int bad_count, n_checks, a, b;
    rvw_top rvw_top_i (.CORE_CLK_IN(clk), .RSTN_IN(rstn), .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr),
        .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
        .POR_IN(por), .LOW_VOLTAGE_RESET_IN(low_voltage_reset), .ILLEGAL_ADDR_IN(ill), .CLKMON_FAIL_IN(cmf),
        .WDOG_TIMEOUT_IN(wdt), .RESET_PIN_N_IN(rpin_n), .NONMASKABLE_IRQ_PIN_N_IN(nmi_n), .IRQ_PIN_N_IN(irq_n),
        .PERIPH_REQ_IN(preq), .CPU_IBIT_IN(ibit), .CPU_XBIT_IN(xbit), .WAIT_INSTR_IN(wait_instruction), .STOP_INSTR_IN(stp),
        .FLASH_BUSY_IN(fbusy), .DEBUG_ACTIVE_IN(dbg), .PERIPH_CLK_OFF_IN(poff), .RESET_REQ_OUT(rreq),
        .RESET_VEC_OUT(rvec), .IRQ_PENDING_OUT(ipend), .NMI_PENDING_OUT(npend), .IRQ_VEC_OUT(ivec),
        .CLK_GATE_OUT(gate), .FREEZE_OUT(frz), .USE_PLL_CLK_OUT(pll), .MODE_OUT(mode));
    rvw_cpu_model rvw_cpu_model_i (.clk_in(clk), .rstn_in(rstn), .ibit_in(ibit), .xbit_in(xbit),
        .irq_pend_in(ipend), .nmi_pend_in(npend), .vec_in(ivec), .fetch_out(fetch), .addr_out(faddr));
    // ----------------
    // helpers
    // ----------------
    // offsets step down by two per source, with gaps at the reserved slots
    function automatic logic [7:0] ofs(input int i);
        if (i < 14) return 8'hf4 - 8'(2 * i);
        if (i < 18) return 8'hd8 - 8'(2 * (i - 14));
        return (i == 18) ? 8'hce : (i == 19) ? 8'hcc : (i == 20) ? 8'hc6 : 8'hc4;
    endfunction
    function automatic logic [31:0] nx(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // request stays up until pready is seen at an edge
    task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1; pen <= 1'b0; pwr <= w; paddr <= ad; pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; pen <= 1'b0;
    endtask
    task automatic instr(input logic w, input logic s);
        @(posedge clk);
        wait_instruction <= w; stp <= s;
        @(posedge clk);
        wait_instruction <= 1'b0; stp <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic req(input logic [21:0] r);
        @(posedge clk);
        preq <= r;
        repeat (4) @(posedge clk);
        #1;
    endtask
    // one-cycle cause pulse, judged right after the edge that samples it
    task automatic cause(input logic [4:0] c, input logic er, input logic [15:0] ev);
        @(posedge clk);
        {por, low_voltage_reset, ill, cmf, wdt} <= c;
        @(posedge clk);
        {por, low_voltage_reset, ill, cmf, wdt} <= 5'h00;
        #1;
        chk("reset_req", 32'(er), 32'(rreq));
        if (er) chk("reset_vec", 32'(ev), 32'(rvec));
    endtask
    task automatic report_and_stop();
        if (bad_count == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // ----------------
    // clock and watchdog
    // ----------------
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // whole sequence needs a few hundred cycles; a hang is cut well beyond that
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        report_and_stop();
    end
    // ----------------
    // main sequence
    // ----------------
    initial begin
        {rstn, psel, pen, pwr, por, low_voltage_reset, ill, cmf, wdt, ibit, xbit, wait_instruction, stp, fbusy, dbg} = '0;
        {rpin_n, nmi_n, irq_n} = 3'b111;
        {paddr, pwdata, preq, poff} = '0;
        lfsr = 32'h1c4d;
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        #1;
        chk("rvec_rst", 32'hfffe, 32'(rvec));
        chk("ivec_rst", 32'hff10, 32'(ivec));
        apb(1'b0, rvw_pkg::ADDR_BASE, 32'h0);
        chk("base_rst", 32'hff, rd);
        apb(1'b0, 12'h024, 32'h0);
        chk("unmapped_err", 32'h1, 32'(err));
        chk("unmapped_rd", 32'h0, rd);
        cause(5'b10000, 1'b1, 16'hfffe);
        cause(5'b01000, 1'b1, 16'hfffe);
        cause(5'b00100, 1'b1, 16'hfffe);
        cause(5'b00001, 1'b0, 16'h0000);
        apb(1'b1, rvw_pkg::ADDR_CTRL, 32'h104);
        cause(5'b00001, 1'b1, 16'hfffa);
        cause(5'b00011, 1'b1, 16'hfffc);
        apb(1'b1, rvw_pkg::ADDR_CTRL, 32'h10c);
        cause(5'b00010, 1'b0, 16'h0000);
        lfsr = nx(lfsr);
        base = lfsr[7:0];
        apb(1'b1, rvw_pkg::ADDR_CTRL, 32'h0);
        apb(1'b1, rvw_pkg::ADDR_BASE, 32'(base));
        apb(1'b1, rvw_pkg::ADDR_EXT_IRQ_ENABLE, 32'h3fffff);
        apb(1'b1, rvw_pkg::ADDR_LEVEL0, 32'h0);
        apb(1'b1, rvw_pkg::ADDR_LEVEL1, 32'h0);
        for (int i = 2; i < 22; i++) begin
            req(22'(1) << i);
            chk("vec_one", 32'({base, ofs(i)}), 32'(ivec));
            chk("fetch", 32'({base, ofs(i)}), 32'(faddr));
        end
        repeat (6) begin
            lfsr = nx(lfsr);
            a = 2 + int'(lfsr[15:0] % 20);
            b = 2 + int'(lfsr[31:16] % 20);
            if (a != b) begin
                req((22'(1) << a) | (22'(1) << b));
                chk("vec_pair", 32'({base, ofs(a < b ? a : b)}), 32'(ivec));
                lev = 44'h1 << (2 * (a < b ? b : a));
                apb(1'b1, rvw_pkg::ADDR_LEVEL0, lev[31:0]);
                apb(1'b1, rvw_pkg::ADDR_LEVEL1, 32'(lev[43:32]));
                req((22'(1) << a) | (22'(1) << b));
                chk("vec_level", 32'({base, ofs(a < b ? b : a)}), 32'(ivec));
                apb(1'b1, rvw_pkg::ADDR_LEVEL0, 32'h0);
                apb(1'b1, rvw_pkg::ADDR_LEVEL1, 32'h0);
            end
        end
        apb(1'b1, rvw_pkg::ADDR_EXT_IRQ_ENABLE, 32'h3fffdf);
        req(22'h000020);
        chk("masked", 32'({1'b0, base, 8'h10}), 32'({ipend, ivec}));
        apb(1'b1, rvw_pkg::ADDR_EXT_IRQ_ENABLE, 32'h3fffff);
        ibit <= 1'b1;
        req(22'h000010);
        chk("ibit_nofetch", 32'h0, 32'(fetch));
        ibit <= 1'b0;
        preq <= '0;
        nmi_n <= 1'b0;
        xbit <= 1'b1;
        req(22'h0);
        chk("nmi_xmask", 32'h0, 32'({npend, fetch}));
        xbit <= 1'b0;
        req(22'h0);
        chk("nmi_vec", 32'({1'b1, base, 8'hf4}), 32'({npend, ivec}));
        nmi_n <= 1'b1;
        irq_n <= 1'b0;
        req(22'h0);
        chk("irq_vec", 32'({base, 8'hf2}), 32'(ivec));
        irq_n <= 1'b1;
        req(22'h0);
        instr(1'b1, 1'b0);
        chk("wait_mode", 32'(rvw_pkg::RVW_WAIT), 32'(mode));
        poff <= 8'hff;
        req(22'h0);
        chk("wait_gate", 32'h0, 32'(gate[0]));
        poff <= 8'h00;
        req(22'h000008);
        chk("wait_wake", 32'(rvw_pkg::RVW_RUN), 32'(mode));
        req(22'h0);
        instr(1'b0, 1'b1);
        chk("fstop", 32'h2, 32'({gate[7], mode}));
        req(22'h000008);
        chk("fstop_timer", 32'(rvw_pkg::RVW_FSTOP), 32'(mode));
        req(22'h008000);
        chk("fstop_serial", 32'(rvw_pkg::RVW_RUN), 32'(mode));
        req(22'h0);
        apb(1'b1, rvw_pkg::ADDR_CTRL, 32'h22);
        instr(1'b0, 1'b1);
        @(posedge clk);
        preq <= 22'h020000;
        @(posedge clk);
        #1;
        chk("fast_atd", 32'h4, 32'({pll, mode}));
        req(22'h0);
        apb(1'b1, rvw_pkg::ADDR_CTRL, 32'h1);
        instr(1'b0, 1'b1);
        chk("pstop", 32'({1'b1, 2'(rvw_pkg::RVW_PSTOP)}), 32'({gate[7], mode}));
        req(22'h000004);
        chk("pstop_tick", 32'(rvw_pkg::RVW_RUN), 32'(mode));
        req(22'h000008);
        instr(1'b0, 1'b1);
        chk("stop_cancel", 32'(rvw_pkg::RVW_RUN), 32'(mode));
        req(22'h0);
        fbusy <= 1'b1;
        instr(1'b0, 1'b1);
        chk("flash_hold", 32'(rvw_pkg::RVW_RUN), 32'(mode));
        req(22'h000008);
        req(22'h0);
        fbusy <= 1'b0;
        req(22'h0);
        chk("flash_cancel", 32'(rvw_pkg::RVW_RUN), 32'(mode));
        apb(1'b1, rvw_pkg::ADDR_FRZ, 32'hf);
        dbg <= 1'b1;
        req(22'h0);
        chk("freeze_on", 32'hf, 32'(frz));
        dbg <= 1'b0;
        req(22'h0);
        chk("freeze_off", 32'h0, 32'(frz));
        report_and_stop();
    end
endmodule

// >>> verification/rvw_top_sva.sv
// ----------------
// port checker for the vector map, mode clock gates, flash hold and freeze
// ----------------
module rvw_top_sva (
    input wire logic CORE_CLK_IN,
    input wire logic RSTN_IN,
    input wire logic POR_IN,
    input wire logic LOW_VOLTAGE_RESET_IN,
    input wire logic ILLEGAL_ADDR_IN,
    input wire logic CLKMON_FAIL_IN,
    input wire logic WDOG_TIMEOUT_IN,
    input wire logic WAIT_INSTR_IN,
    input wire logic STOP_INSTR_IN,
    input wire logic FLASH_BUSY_IN,
    input wire logic DEBUG_ACTIVE_IN,
    input wire logic [7:0] PERIPH_CLK_OFF_IN,
    input wire logic RESET_REQ_OUT,
    input wire logic [15:0] RESET_VEC_OUT,
    input wire logic IRQ_PENDING_OUT,
    input wire logic NMI_PENDING_OUT,
    input wire logic [15:0] IRQ_VEC_OUT,
    input wire logic [7:0] CLK_GATE_OUT,
    input wire logic [3:0] FREEZE_OUT,
    input wire logic [1:0] MODE_OUT
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge CORE_CLK_IN); endclocking
    default disable iff (!RSTN_IN);
    // the top causes outrank both dedicated vectors, so those are judged alone
    wire logic top_c = POR_IN | LOW_VOLTAGE_RESET_IN | ILLEGAL_ADDR_IN;
    a_top_reset_vec: assert property (top_c |=> RESET_REQ_OUT && RESET_VEC_OUT == 16'hfffe)
        else $error("top reset cause without top vector");
    a_clkmon_own_vec: assert property (CLKMON_FAIL_IN && !top_c && !WDOG_TIMEOUT_IN
        |=> !RESET_REQ_OUT || RESET_VEC_OUT == 16'hfffc)
        else $error("clock monitor reset on wrong vector");
    a_wdog_own_vec: assert property (WDOG_TIMEOUT_IN && !top_c && !CLKMON_FAIL_IN
        |=> !RESET_REQ_OUT || RESET_VEC_OUT == 16'hfffa)
        else $error("watchdog reset on wrong vector");
    a_vec_in_table: assert property ((IRQ_PENDING_OUT || NMI_PENDING_OUT) |-> !IRQ_VEC_OUT[0]
        && IRQ_VEC_OUT[7:0] inside {[8'hc4:8'hf4]} && !(IRQ_VEC_OUT[7:0] inside {8'hc8, 8'hca, 8'hd0}))
        else $error("vector offset outside table");
    a_none_spurious: assert property (!IRQ_PENDING_OUT && !NMI_PENDING_OUT |-> IRQ_VEC_OUT[7:0] == 8'h10)
        else $error("idle vector not spurious");
    a_wait_entry: assert property (MODE_OUT == rvw_pkg::RVW_RUN && WAIT_INSTR_IN && !STOP_INSTR_IN
        && !IRQ_PENDING_OUT && !NMI_PENDING_OUT |=> MODE_OUT == rvw_pkg::RVW_WAIT)
        else $error("wait instruction did not enter wait");
    a_wait_gates: assert property (MODE_OUT == rvw_pkg::RVW_WAIT |-> CLK_GATE_OUT[7:5] == 3'b101
        && CLK_GATE_OUT[0] == !(&PERIPH_CLK_OFF_IN))
        else $error("wait clock gates wrong");
    a_fstop_gates: assert property (MODE_OUT == rvw_pkg::RVW_FSTOP |-> (CLK_GATE_OUT & 8'hf9) == 8'h00)
        else $error("full stop clocks left on");
    a_pstop_gates: assert property (MODE_OUT == rvw_pkg::RVW_PSTOP
        |-> CLK_GATE_OUT[7] && CLK_GATE_OUT[6:5] == 2'b00 && !CLK_GATE_OUT[0])
        else $error("pseudo stop clock gates wrong");
    a_flash_hold: assert property (MODE_OUT == rvw_pkg::RVW_RUN && STOP_INSTR_IN && FLASH_BUSY_IN
        |=> MODE_OUT == rvw_pkg::RVW_RUN)
        else $error("stop entered while flash busy");
    a_freeze_debug: assert property (!DEBUG_ACTIVE_IN |-> FREEZE_OUT == 4'h0)
        else $error("freeze without debug");
endmodule

bind rvw_top rvw_top_sva rvw_top_sva_i (.CORE_CLK_IN, .RSTN_IN, .POR_IN, .LOW_VOLTAGE_RESET_IN,
    .ILLEGAL_ADDR_IN, .CLKMON_FAIL_IN, .WDOG_TIMEOUT_IN, .WAIT_INSTR_IN, .STOP_INSTR_IN, .FLASH_BUSY_IN,
    .DEBUG_ACTIVE_IN, .PERIPH_CLK_OFF_IN, .RESET_REQ_OUT, .RESET_VEC_OUT, .IRQ_PENDING_OUT, .NMI_PENDING_OUT,
    .IRQ_VEC_OUT, .CLK_GATE_OUT, .FREEZE_OUT, .MODE_OUT);
